// ---- dv/rtsg_chk.sv ----
`timescale 1ns/10ps
module rtsg_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic tone_20k,
	input wire logic tone_4k8,
	input wire logic tone_4k0,
	input wire logic data_req,
	input wire logic i_chan,
	input wire logic q_chan,
	input wire logic tx_gate
);
	logic [6:0] ctrl_q;
	logic hi_q;
	wire en = ctrl_q[6];
	wire pn = en && ctrl_q[1:0] == 2'h1;
	wire burst = ctrl_q[1:0] == 2'h2;
	wire ret = ctrl_q[3:2] == 2'h2;
	wire gon = en && !burst && !ret;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 7'h00;
			hi_q <= 1'b0;
		end else begin
			if (psel && penable && pwrite && paddr == 8'h00)
				ctrl_q <= pwdata[6:0];
			if (tone_20k && tone_4k8 && tone_4k0)
				hi_q <= 1'b1;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence on_hold;
		tx_gate [*8];
	endsequence
	req_pulse_a: assert property (data_req |=> !data_req)
		else $error("data request too long");
	pn_quiet_a: assert property (pn && $past(pn) |-> !q_chan)
		else $error("range bit in code mode");
	ret_gate_a: assert property (ret && $past(ret) |-> !tx_gate)
		else $error("gate on in return-only link");
	off_quiet_a: assert property (
		!en && $past(!en) |-> !(i_chan || q_chan || tx_gate))
		else $error("output active while disabled");
	range_early_a: assert property (q_chan |-> hi_q)
		else $error("range bit before coincidence");
	gate_on_a: assert property (
		gon && $past(gon) && $past(gon, 2) |-> tx_gate)
		else $error("gate off outside burst mode");
	gate_hold_a: assert property (
		burst && $rose(tx_gate) |=> on_hold)
		else $error("burst shorter than eight cycles");
	bad_addr_a: assert property (
		psel && penable && paddr > 8'h0c |-> pslverr)
		else $error("unmapped access not refused");
endmodule
bind rtsg_top rtsg_chk rtsg_chk_inst (.pclk, .presetn, .paddr, .psel,
	.penable, .pwrite, .pwdata, .pslverr, .tone_20k, .tone_4k8,
	.tone_4k0, .data_req, .i_chan, .q_chan, .tx_gate);

// ---- dv/rtsg_tone_src.sv ----
`timescale 1ns/10ps
module rtsg_tone_src (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	output logic tone_20k,
	output logic tone_4k8,
	output logic tone_4k0,
	output logic [8:0] ph
);
	// Scaled tones, periods 12, 50, 60; all rise at ph 0
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ph <= 9'h000;
		else if (run)
			ph <= (ph == 9'h12b) ? 9'h000 : ph + 9'h001;
	end
	assign tone_20k = run && ph % 12 < 6;
	assign tone_4k8 = run && ph % 50 < 25;
	assign tone_4k0 = run && ph % 60 < 30;
endmodule

// ---- dv/test_range_tone_sequence_generator.sv ----
`timescale 1ns/10ps
`include "rtsg_consts.svh"
`define CK(g, x) begin num_checks++; if ((g) !== (x)) begin n_errors++; \
	$display("[ERR] %0t got %h want %h", $time, g, x); end end
module test_range_tone_sequence_generator;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, run = 1'b0, data_in = 1'b0, pn_chip = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, r;
	logic [5:0] preset_addr = 6'h00;
	logic pready, pslverr, tone_20k, tone_4k8, tone_4k0, e;
	logic data_req, i_chan, q_chan, tx_gate;
	logic [8:0] ph;
	logic [49:0] seq = `RTSG_SEQ_INIT;
	logic ex[$];
	int n_errors = 0, num_checks = 0, pre, cyc = 0;
	rtsg_top #(.CYC_PER_MS(20)) rtsg_top_inst (.pclk, .presetn, .paddr,
		.psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.tone_20k, .tone_4k8, .tone_4k0, .preset_addr, .data_in,
		.pn_chip, .data_req, .i_chan, .q_chan, .tx_gate);
	rtsg_tone_src rtsg_tone_src_inst (.pclk, .presetn, .run, .tone_20k,
		.tone_4k8, .tone_4k0, .ph);
	initial forever #12.5 pclk = ~pclk;
	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic reg_chk(input logic [7:0] a, input logic [31:0] x,
		input logic xe);
		apb(1'b0, a, 32'h0);
		`CK(rd, x)
		`CK(e, xe)
		`CK(pready, 1'b1)
	endtask
	task automatic seq_chk(input int f);
		for (int k = 0; k < 100; k++) begin
			@(negedge pclk);
			while (ph % 6 != 1) @(negedge pclk);
			`CK(q_chan, seq[(pre + ph / 6 + 48 + f) % 50])
		end
	endtask
	task automatic man_chk(input logic pnm);
		logic d;
		for (int k = 0; k < 6; k++) begin
			do @(negedge pclk); while (data_req !== 1'b1);
			d = data_in;
			r = $urandom;
			ex.push_back(d ^ (pnm & r[0]));
			ex.push_back(pnm ? d ^ r[0] : ~d);
			@(posedge pclk) data_in <= r[1];
			pn_chip <= r[0];
			repeat (7) @(negedge pclk);
			`CK(i_chan, ex.pop_front())
			repeat (18) @(negedge pclk);
			`CK(i_chan, ex.pop_front())
		end
	endtask
	task automatic gate_chk(input int f);
		int n;
		n = 0;
		apb(1'b1, 8'h00, 32'h42 | (f << 4));
		do @(negedge pclk); while (tx_gate !== 1'b0);
		do @(negedge pclk); while (tx_gate !== 1'b1);
		do begin
			@(negedge pclk);
			n++;
		end while (tx_gate === 1'b1);
		`CK(n, 40 * (f + 1))
	endtask
	initial begin
		r = $urandom(32'h7718f259);
		pre = $urandom_range(49, 0);
		@(posedge pclk) preset_addr <= 6'(pre);
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		reg_chk(8'h08, 32'h4e20, 1'b0);
		apb(1'b1, 8'h08, 32'h0010);
		reg_chk(8'h00, 32'h0, 1'b0);
		reg_chk(8'h04, 32'h0, 1'b0);
		apb(1'b0, 8'h0c, 32'h0);
		`CK(rd[21:16], 6'(pre))
		apb(1'b1, 8'h0c, 32'hffff);
		`CK(e, 1'b1)
		apb(1'b1, 8'h10, 32'h1);
		reg_chk(8'h10, 32'h0, 1'b1);
		$display("registers done");
		apb(1'b1, 8'h00, 32'h0040);
		repeat (20) begin
			@(negedge pclk);
			`CK(q_chan, 1'b0)
		end
		@(posedge pclk) run <= 1'b1;
		repeat (400) @(negedge pclk);
		seq_chk(0);
		`CK(tx_gate, 1'b1)
		apb(1'b1, 8'h04, 32'h0004);
		repeat (320) @(negedge pclk);
		seq_chk(1);
		apb(1'b1, 8'h04, 32'h0);
		$display("sequence done");
		man_chk(1'b0);
		apb(1'b1, 8'h00, 32'h0041);
		man_chk(1'b1);
		`CK(q_chan, 1'b0)
		$display("data done");
		for (int f = 0; f < 4; f++) gate_chk(f);
		for (int l = 0; l < 3; l++) begin
			apb(1'b1, 8'h00, 32'h43 | (l << 2));
			repeat (5) @(negedge pclk);
			`CK(tx_gate, 1'(l != 2))
		end
		$display("gating done");
		give_verdict();
	end
endmodule

// ---- hw/rtsg_seq_rom.sv ----
`timescale 1ns/10ps
`include "rtsg_consts.svh"
module rtsg_seq_rom #(
	parameter int LEN = `RTSG_SEQ_LEN,
	parameter int AW = `RTSG_AW,
	parameter logic [LEN-1:0] SEQ_INIT = `RTSG_SEQ_INIT
) (
	input wire logic pclk,
	input wire logic presetn,
	rtsg_seq_if.rom sq
);
	localparam logic [AW-1:0] LAST = AW'(LEN - 1);

	logic [LEN-1:0] rom_bits;
	logic [AW-1:0] addr_q;
	logic [AW-1:0] addr_d;
	logic bit_q;
	wire logic [AW-1:0] start_addr;
	wire logic [AW-1:0] step_addr;

	assign rom_bits = SEQ_INIT;
	// Out-of-range presets restart at the first bit
	assign start_addr = (sq.preset <= LAST) ? sq.preset : '0;
	assign step_addr = (addr_q == LAST) ? '0 : addr_q + 1'b1;
	assign addr_d = sq.load ? start_addr : step_addr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_q <= '0;
			bit_q <= 1'b0;
		end else if (sq.tick) begin
			addr_q <= addr_d;
			bit_q <= rom_bits[addr_d];
		end
	end

	assign sq.addr = addr_q;
	assign sq.seq_bit = bit_q;
endmodule

// ---- hw/rtsg_top.sv ----
`timescale 1ns/10ps
`include "rtsg_consts.svh"
module rtsg_top #(
	parameter int LEN = `RTSG_SEQ_LEN,
	parameter int AW = `RTSG_AW,
	parameter int CYC_PER_MS = `RTSG_CLK_HZ / `RTSG_MS_PER_S,
	parameter int COINC_WIN = `RTSG_COINC_WIN
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tone_20k,
	input wire logic tone_4k8,
	input wire logic tone_4k0,
	input wire logic [AW-1:0] preset_addr,
	input wire logic data_in,
	input wire logic pn_chip,
	output logic data_req,
	output logic i_chan,
	output logic q_chan,
	output logic tx_gate
);
	localparam int BIT_CYC = `RTSG_CLK_HZ / `RTSG_BIT_RATE;
	localparam int MSW = $clog2(CYC_PER_MS + 1);
	localparam int CWW = $clog2(COINC_WIN + 1);
	localparam logic [MSW-1:0] MS_LAST = MSW'(CYC_PER_MS - 1);
	localparam logic [CWW-1:0] WIN = CWW'(COINC_WIN);
	localparam logic [3:0] BSTEP = 4'(`RTSG_BURST_MS_STEP);

	////////////////////////////////////////////////////////////////
	// Register bus
	logic [`RTSG_CTRL_W-1:0] ctrl_q;
	logic [`RTSG_FINE_W-1:0] fine_q;
	logic [`RTSG_DHALF_W-1:0] dhalf_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic [31:0] stat_w;
	wire logic setup_ph;
	wire logic wr_acc;
	wire logic sel_ctrl;
	wire logic sel_fine;
	wire logic sel_dhalf;
	wire logic sel_stat;
	wire logic hit;
	logic [31:0] rd_mux;

	assign setup_ph = psel && !penable;
	assign wr_acc = psel && penable && pwrite;
	assign sel_ctrl = paddr == `RTSG_OFF_CTRL;
	assign sel_fine = paddr == `RTSG_OFF_FINE;
	assign sel_dhalf = paddr == `RTSG_OFF_DHALF;
	assign sel_stat = paddr == `RTSG_OFF_STAT;
	assign hit = sel_ctrl || sel_fine || sel_dhalf || sel_stat;
	assign rd_mux = sel_ctrl ? 32'(ctrl_q) :
		sel_fine ? 32'(fine_q) :
		sel_dhalf ? 32'(dhalf_q) :
		sel_stat ? stat_w : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (setup_ph) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr_q <= !hit || (pwrite && sel_stat);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `RTSG_CTRL_RST;
			fine_q <= `RTSG_FINE_RST;
			dhalf_q <= `RTSG_DHALF_RST;
		end else if (wr_acc) begin
			if (sel_ctrl)
				ctrl_q <= pwdata[`RTSG_CTRL_W-1:0];
			if (sel_fine)
				fine_q <= pwdata[`RTSG_FINE_W-1:0];
			if (sel_dhalf)
				dhalf_q <= pwdata[`RTSG_DHALF_W-1:0];
		end
	end

	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q && psel && penable;

	////////////////////////////////////////////////////////////////
	// Mode decode
	wire logic [1:0] mode_f;
	wire logic [1:0] link_f;
	wire logic [1:0] fmt_f;
	wire logic enable;
	wire logic mode_pn;
	wire logic mode_burst;
	wire logic link_on;

	assign mode_f = ctrl_q[`RTSG_CTRL_MODE];
	assign link_f = ctrl_q[`RTSG_CTRL_LINK];
	assign fmt_f = ctrl_q[`RTSG_CTRL_FMT];
	assign enable = ctrl_q[`RTSG_CTRL_EN];
	// Unused mode code falls back to plain phase shift
	assign mode_pn = mode_f == rtsg_pkg::RTSG_MOD_PN;
	assign mode_burst = mode_f == rtsg_pkg::RTSG_MOD_BURST;
	assign link_on = link_f != rtsg_pkg::RTSG_LINK_RET;

	////////////////////////////////////////////////////////////////
	// Tone crossing detection
	logic [2:0] tone_prev_q;
	wire logic [2:0] tone_now;
	wire logic [2:0] tone_rise;
	logic [2:0] recent;
	logic fired_q;
	wire logic coinc;
	wire logic edge_20k;

	assign tone_now = {tone_4k0, tone_4k8, tone_20k};
	assign tone_rise = tone_now & ~tone_prev_q;
	assign edge_20k = tone_now[0] ^ tone_prev_q[0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tone_prev_q <= 3'h0;
		else
			tone_prev_q <= tone_now;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_age
			logic [CWW-1:0] age_q;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					age_q <= '0;
				else if (tone_rise[gi])
					age_q <= WIN;
				else if (age_q != '0)
					age_q <= age_q - 1'b1;
			end
			assign recent[gi] = tone_rise[gi] || (age_q != '0);
		end
	endgenerate

	// Fire once per window in which all three tones crossed
	assign coinc = (&recent) && !fired_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fired_q <= 1'b0;
		else
			fired_q <= &recent;
	end

	////////////////////////////////////////////////////////////////
	// Bit clock with fine delay
	logic [`RTSG_FINE_W-1:0] fd_cnt_q;
	logic fd_busy_q;
	wire logic bit_tick;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fd_cnt_q <= '0;
			fd_busy_q <= 1'b0;
		end else if (edge_20k && fine_q != '0) begin
			fd_cnt_q <= fine_q;
			fd_busy_q <= 1'b1;
		end else if (fd_busy_q) begin
			fd_cnt_q <= fd_cnt_q - 1'b1;
			fd_busy_q <= fd_cnt_q != `RTSG_FINE_W'(1);
		end
	end

	// Both tone edges give twice the tone rate
	assign bit_tick = (edge_20k && fine_q == '0) ||
		(fd_busy_q && fd_cnt_q == `RTSG_FINE_W'(1));

	////////////////////////////////////////////////////////////////
	// Sequence alignment and memory
	rtsg_pkg::rtsg_align_e al_q;
	logic load_pend_q;

	rtsg_seq_if #(.AW(AW)) sq ();

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_pend_q <= 1'b0;
			al_q <= rtsg_pkg::RTSG_AL_WAIT;
		end else begin
			if (coinc)
				load_pend_q <= 1'b1;
			else if (bit_tick)
				load_pend_q <= 1'b0;
			case (al_q)
				rtsg_pkg::RTSG_AL_WAIT: begin
					if (bit_tick && load_pend_q)
						al_q <= rtsg_pkg::RTSG_AL_RUN;
				end
				rtsg_pkg::RTSG_AL_RUN: begin
					al_q <= rtsg_pkg::RTSG_AL_RUN;
				end
				default: begin
					al_q <= rtsg_pkg::RTSG_AL_WAIT;
				end
			endcase
		end
	end

	assign sq.tick = bit_tick;
	assign sq.load = load_pend_q;
	assign sq.preset = preset_addr;

	rtsg_seq_rom #(
		.LEN(LEN),
		.AW(AW)
	) u_rom (
		.pclk(pclk),
		.presetn(presetn),
		.sq(sq)
	);

	////////////////////////////////////////////////////////////////
	// Manchester data path
	logic [`RTSG_DHALF_W-1:0] half_cnt_q;
	logic half_ph_q;
	logic dbit_q;
	logic data_req_q;
	wire logic half_end;
	wire logic man_bit;

	assign half_end = half_cnt_q >= dhalf_q - 1'b1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_cnt_q <= '0;
			half_ph_q <= 1'b0;
			dbit_q <= 1'b0;
			data_req_q <= 1'b0;
		end else begin
			data_req_q <= 1'b0;
			if (!enable) begin
				half_cnt_q <= '0;
				half_ph_q <= 1'b0;
			end else if (half_end) begin
				half_cnt_q <= '0;
				half_ph_q <= !half_ph_q;
				if (half_ph_q) begin
					dbit_q <= data_in;
					data_req_q <= 1'b1;
				end
			end else begin
				half_cnt_q <= half_cnt_q + 1'b1;
			end
		end
	end

	// Outside PN mode, data passes uncoded apart from line coding
	assign man_bit = dbit_q ^ half_ph_q;

	////////////////////////////////////////////////////////////////
	// Burst gating
	logic [MSW-1:0] ms_cnt_q;
	logic [3:0] bms_q;
	logic gate_q;
	wire logic ms_tick;
	wire logic [3:0] burst_ms;

	assign ms_tick = ms_cnt_q == MS_LAST;
	assign burst_ms = 4'({2'h0, fmt_f} + 4'h1) * BSTEP;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt_q <= '0;
			bms_q <= 4'h0;
			gate_q <= 1'b1;
		end else if (!mode_burst || !enable) begin
			ms_cnt_q <= '0;
			bms_q <= 4'h0;
			gate_q <= 1'b1;
		end else begin
			ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
			if (ms_tick) begin
				if (bms_q >= burst_ms - 4'h1) begin
					bms_q <= 4'h0;
					gate_q <= !gate_q;
				end else begin
					bms_q <= bms_q + 4'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Output stage
	logic i_q;
	logic q_q;
	logic tx_q;
	wire logic aligned;

	assign aligned = al_q == rtsg_pkg::RTSG_AL_RUN;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			i_q <= 1'b0;
			q_q <= 1'b0;
			tx_q <= 1'b0;
		end else begin
			i_q <= enable && (mode_pn ? (dbit_q ^ pn_chip) : man_bit);
			q_q <= enable && !mode_pn && aligned && sq.seq_bit;
			tx_q <= enable && link_on && gate_q;
		end
	end

	assign i_chan = i_q;
	assign q_chan = q_q;
	assign tx_gate = tx_q;
	assign data_req = data_req_q;

	assign stat_w = {8'h00, 2'h0, sq.preset, 2'h0, sq.addr,
		5'h00, load_pend_q, gate_q, aligned};

	// Unused in logic; documents the nominal tone-derived bit period
	localparam int NOMINAL_BIT_CYC = BIT_CYC;
endmodule

// ---- include/rtsg_consts.svh ----
`ifndef RTSG_CONSTS_SVH
`define RTSG_CONSTS_SVH

// Clock and timing
`define RTSG_CLK_HZ 40000000
`define RTSG_BIT_RATE 40000
`define RTSG_MS_PER_S 1000
`define RTSG_COINC_WIN 8
`define RTSG_BURST_MS_STEP 2

// Sequence memory
`define RTSG_SEQ_LEN 50
`define RTSG_AW 6
`define RTSG_SEQ_INIT 50'h2b6d91e3ca5f0

// Register byte offsets
`define RTSG_OFF_CTRL 8'h00
`define RTSG_OFF_FINE 8'h04
`define RTSG_OFF_DHALF 8'h08
`define RTSG_OFF_STAT 8'h0c

// Control register fields
`define RTSG_CTRL_MODE 1:0
`define RTSG_CTRL_LINK 3:2
`define RTSG_CTRL_FMT 5:4
`define RTSG_CTRL_EN 6
`define RTSG_CTRL_W 7

// Status register fields
`define RTSG_STAT_ALIGN 0
`define RTSG_STAT_GATE 1
`define RTSG_STAT_PEND 2
`define RTSG_STAT_ADDR 13:8
`define RTSG_STAT_PRESET 21:16

// Field widths and reset values
`define RTSG_FINE_W 8
`define RTSG_DHALF_W 16
`define RTSG_CTRL_RST 7'h00
`define RTSG_FINE_RST 8'h00
`define RTSG_DHALF_RST 16'h4e20

`endif

// ---- include/rtsg_pkg.sv ----
package rtsg_pkg;

	typedef enum logic [1:0] {
		RTSG_MOD_PSK = 2'h0,
		RTSG_MOD_PN = 2'h1,
		RTSG_MOD_BURST = 2'h2
	} rtsg_mode_e;

	typedef enum logic [1:0] {
		RTSG_LINK_FWD = 2'h0,
		RTSG_LINK_XPND = 2'h1,
		RTSG_LINK_RET = 2'h2
	} rtsg_link_e;

	typedef enum logic [0:0] {
		RTSG_AL_WAIT = 1'h0,
		RTSG_AL_RUN = 1'h1
	} rtsg_align_e;

endpackage

// ---- include/rtsg_seq_if.sv ----
`timescale 1ns/10ps
interface rtsg_seq_if #(parameter int AW = 6);
	logic tick;
	logic load;
	logic [AW-1:0] preset;
	logic seq_bit;
	logic [AW-1:0] addr;

	modport ctl (output tick, output load, output preset,
		input seq_bit, input addr);
	modport rom (input tick, input load, input preset,
		output seq_bit, output addr);
endinterface
